// *** logic/uieid_core.sv ***
`default_nettype none
// How it works
// - Mask bits 7,6,3,2,0 enable CTS/DSR, RTS/DTR, modem, line status, receive data.
// - Mask bit 5 enables the software flow control interrupt.
// - Mask bit 1: transmit ready on empty holding, or free space above trigger.
// - Mask bits 7..4 are writable only while extended unlock bit is 1.
// - Mask bit 4 enables sleep, effective only with extended unlock set.
// - Sleep entry needs no pending interrupt, stable modem, idle receive, empty queues.
// - Modem toggle, receive low, or transmit write wakes the channel.
// - Sleep stops the oscillator; wake detection is combinational, needs no clock.
// - Offset 1 is divisor high byte when line format bit 7 set, not 0xbf.
// - Offset 1 is the mask register when line format bit 7 is 0; resets zero.
// - Source bit 0 reads 1 when nothing pending, 0 when pending.
// - Codes: line 000110 p1, timeout 001100, data 000100 p2, tx 000010, modem 000000.
// - Input pin change reports 110000 at priority 5.
// - Xoff or special character reports 010000 at priority 6.
// - CTS/RTS going inactive reports 100000 at priority 7.
// - Xoff cause cleared by Xon; special character cause cleared by source read.
// - Queue enable selects 64-entry queues, else single-character holding.
module uieid_core
  import uieid_pkg::*;
#(
  parameter int QDEPTH = uieid_pkg::FIFO_DEPTH
) (
  // Clock and resets
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      porRstn,
  // Host register port
  input  wire uieid_pkg::uieid_hostreq_t hostReq,
  output logic                    [7:0]  hostRdata,
  // Configuration from neighbouring registers
  input  wire logic               [7:0]  lineFormat,
  input  wire logic               [7:0]  extFeature,
  // Channel status
  input  wire uieid_pkg::uieid_events_t  events,
  input  wire uieid_pkg::uieid_queue_t   queue,
  input  wire logic                      modemToggle,
  input  wire logic                      rxPin,
  input  wire logic                      txWrite,
  // Results
  output logic                    [7:0]  interruptMaskReg,
  output logic                    [7:0]  baudDivisorHigh,
  output logic                    [7:0]  interruptSourceReg,
  output logic                           irqPending,
  output logic                           sleepStopOsc,
  output logic                           wakeRequest
);
  import uieid_pkg::*;

  // Elaboration guard: the mirrored enable bit only knows the one depth
  if (QDEPTH != FIFO_DEPTH) begin : g_badDepth
    $error("uieid_core: queue depth must be 64");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   mask;
    logic [7:0]   source;
    logic [7:0]   divHi;
    uieid_sleep_t slp;
  } uieid_state_t;

  uieid_state_t st_reg;
  uieid_state_t st_next;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic dlabOpen;
  logic unlocked;
  logic maskWr;
  logic divWr;
  logic srcRd;
  // Offset 1 under the extended key matches neither register and reads zero
  assign dlabOpen = lineFormat[LFMT_DLAB] && (lineFormat != LFMT_EXT_KEY);
  assign unlocked = extFeature[EXT_UNLOCK];
  assign maskWr   = hostReq.sel && hostReq.wr && hostReq.addr == OFF_MASK && !lineFormat[LFMT_DLAB];
  assign divWr    = hostReq.sel && hostReq.wr && hostReq.addr == OFF_MASK && dlabOpen;
  assign srcRd    = hostReq.sel && hostReq.rd && hostReq.addr == OFF_SOURCE && !lineFormat[LFMT_DLAB];

  // ---------------------------------------------------------------------------
  // Flow-control causes are sticky
  // ---------------------------------------------------------------------------
  logic xoffFlag;
  logic specFlag;
  uieid_sticky u_xoff (
    .mclk  (mclk),
    .rstn  (rstn),
    .setEn (events.xoffSeen),
    .clrEn (events.xonSeen),
    .flag  (xoffFlag)
  );
  uieid_sticky u_spec (
    .mclk  (mclk),
    .rstn  (rstn),
    .setEn (events.specialSeen),
    .clrEn (srcRd),
    .flag  (specFlag)
  );

  // ---------------------------------------------------------------------------
  // Transmit ready condition
  // ---------------------------------------------------------------------------
  logic txReady;
  // Non-queue mode uses the holding flag; queue mode compares free space
  assign txReady = queue.fifoEnable ? (queue.txFree > queue.txTrigger) : queue.txHoldEmpty;

  // ---------------------------------------------------------------------------
  // Priority pick over enabled sources, index 0 highest
  // ---------------------------------------------------------------------------
  logic [7:0] req;
  logic [7:0] grant;
  logic       anyReq;
  always_comb begin
    req[0] = events.lineErr     && st_reg.mask[M_LINE];
    req[1] = events.rxTimeout   && st_reg.mask[M_RXDATA];
    req[2] = events.rxData      && st_reg.mask[M_RXDATA];
    req[3] = txReady            && st_reg.mask[M_TXRDY];
    req[4] = events.modemChange && st_reg.mask[M_MODEM];
    req[5] = events.pinChange   && st_reg.mask[M_RTSDTR];
    req[6] = (xoffFlag || specFlag) && st_reg.mask[M_SWFC];
    req[7] = events.ctsRtsOff   && st_reg.mask[M_CTSDSR];
  end

  uieid_prio_pick #(.N(8)) u_pick (
    .req   (req),
    .grant (grant),
    .any   (anyReq)
  );

  // Code for the winner; unselected sources never reach the code
  logic [5:0] code;
  always_comb begin
    code = CODE_NONE;
    unique case (1'b1)
      grant[0]: code = CODE_LINE;
      grant[1]: code = CODE_RXTO;
      grant[2]: code = CODE_RXDATA;
      grant[3]: code = CODE_TXRDY;
      grant[4]: code = CODE_MODEM;
      grant[5]: code = CODE_PIN;
      grant[6]: code = CODE_SWFC;
      grant[7]: code = CODE_CTSRTS;
      default:  code = CODE_NONE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sleep conditions
  // ---------------------------------------------------------------------------
  logic sleepArmed;
  logic sleepOk;
  assign sleepArmed  = st_reg.mask[M_SLEEP] && unlocked;
  assign sleepOk     = sleepArmed && !anyReq && !modemToggle && rxPin
                       && queue.txEmpty && queue.rxEmpty;
  // Combinational so wake works while the oscillator is stopped
  assign wakeRequest = modemToggle || !rxPin || txWrite;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (maskWr) begin
      st_next.mask[3:0] = hostReq.wdata[3:0];
      if (unlocked) st_next.mask[7:4] = hostReq.wdata[7:4];
    end
    if (divWr) st_next.divHi = hostReq.wdata;
    st_next.source = {queue.fifoEnable, queue.fifoEnable, code};
    unique case (st_reg.slp)
      SLP_AWAKE:  if (sleepOk && !wakeRequest) st_next.slp = SLP_ASLEEP;
      SLP_ASLEEP: if (wakeRequest || !sleepArmed) st_next.slp = SLP_AWAKE;
      default:    st_next.slp = SLP_AWAKE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Soft reset leaves the divisor alone so a running baud rate survives it
  always_ff @(posedge mclk) begin
    st_reg <= st_next;
    if (!rstn) begin
      st_reg.mask   <= MASK_RESET;
      st_reg.source <= SOURCE_IDLE;
      st_reg.slp    <= SLP_AWAKE;
    end
    if (!porRstn) begin
      st_reg.divHi <= DIVHI_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs and read data
  // ---------------------------------------------------------------------------
  assign interruptMaskReg   = st_reg.mask;
  assign baudDivisorHigh    = st_reg.divHi;
  assign interruptSourceReg = st_reg.source;
  assign irqPending         = !st_reg.source[0];
  assign sleepStopOsc       = (st_reg.slp == SLP_ASLEEP) && !wakeRequest;

  always_comb begin
    hostRdata = 8'h00;
    if (hostReq.addr == OFF_MASK) hostRdata = dlabOpen ? st_reg.divHi
                                            : (lineFormat[LFMT_DLAB] ? 8'h00 : st_reg.mask);
    else if (hostReq.addr == OFF_SOURCE && !lineFormat[LFMT_DLAB]) hostRdata = st_reg.source;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_lockedWrite;
    maskWr && !unlocked;
  endsequence

  chk_upper_mask_locked: assert property (s_lockedWrite |=> interruptMaskReg[7:4] == $past(interruptMaskReg[7:4]))
    else $error("upper mask bits changed while locked");
  chk_lower_mask_write: assert property (maskWr |=> interruptMaskReg[3:0] == $past(hostReq.wdata[3:0]))
    else $error("lower mask bits not written");
  chk_divisor_write: assert property (divWr && porRstn |=> baudDivisorHigh == $past(hostReq.wdata))
    else $error("divisor high byte not written");
  chk_divisor_key_block: assert property (hostReq.sel && hostReq.wr && hostReq.addr == OFF_MASK
                                          && lineFormat == LFMT_EXT_KEY && porRstn
                                          |=> $stable(baudDivisorHigh))
    else $error("divisor written under extended key");
  chk_line_top_prio: assert property (events.lineErr && st_reg.mask[M_LINE] |=> interruptSourceReg[5:0] == CODE_LINE)
    else $error("line status not reported first");
  chk_none_pending: assert property (req == 8'h00 |=> interruptSourceReg[5:0] == CODE_NONE)
    else $error("idle source code wrong");
  chk_mirror_fifo: assert property (1'b1 |=> interruptSourceReg[7:6] == {2{$past(queue.fifoEnable)}})
    else $error("fifo enable mirror wrong");
  chk_xoff_clear: assert property (xoffFlag && events.xonSeen && !events.xoffSeen |=> !xoffFlag)
    else $error("xoff cause not cleared by xon");
  chk_special_clear: assert property (specFlag && srcRd && !events.specialSeen |=> !specFlag)
    else $error("special cause not cleared by read");
  chk_sleep_entry: assert property (st_reg.slp == SLP_AWAKE ##1 st_reg.slp == SLP_ASLEEP
                                    |-> $past(sleepOk))
    else $error("sleep entered without conditions");
  chk_wake_exit: assert property (st_reg.slp == SLP_ASLEEP && wakeRequest |=> st_reg.slp == SLP_AWAKE)
    else $error("no wake on request");
  chk_osc_run_wake: assert property (wakeRequest |-> !sleepStopOsc)
    else $error("oscillator stopped during wake");
  chk_sleep_lock: assert property (!unlocked |=> st_reg.slp == SLP_AWAKE || $past(st_reg.slp) == SLP_AWAKE)
    else $error("sleep held without unlock");
  chk_masked_hidden: assert property (!st_reg.mask[M_CTSDSR] && req[6:0] == 7'h00 |=> interruptSourceReg[0])
    else $error("masked source shown");

  // ---------------------------------------------------------------------------
  // Register port and reset checks
  // ---------------------------------------------------------------------------
  // Write at offset 1 while line format bit 7 is set, extended key included
  sequence s_dlabWrite;
    hostReq.sel && hostReq.wr && hostReq.addr == OFF_MASK && lineFormat[LFMT_DLAB];
  endsequence

  // Soft reset alone, with no divisor write racing it
  sequence s_softOnly;
    !rstn && porRstn && !divWr;
  endsequence

  chk_mask_dlab_block: assert property (s_dlabWrite |=> $stable(interruptMaskReg))
    else $error("mask written while divisor selected");
  chk_upper_mask_write: assert property (maskWr && unlocked
                                         |=> interruptMaskReg[7:4] == $past(hostReq.wdata[7:4]))
    else $error("upper mask bits not written");
  chk_divisor_soft_keep: assert property (disable iff (1'b0) s_softOnly |=> $stable(baudDivisorHigh))
    else $error("divisor disturbed by soft reset");
  chk_reset_idle: assert property (disable iff (1'b0) !rstn |=> interruptSourceReg == SOURCE_IDLE
                                   && interruptMaskReg == MASK_RESET)
    else $error("soft reset values wrong");
  chk_mask_read: assert property (hostReq.addr == OFF_MASK && !lineFormat[LFMT_DLAB]
                                  |-> hostRdata == interruptMaskReg)
    else $error("mask read data wrong");
  chk_source_read: assert property (hostReq.addr == OFF_SOURCE && !lineFormat[LFMT_DLAB]
                                    |-> hostRdata == interruptSourceReg)
    else $error("source read data wrong");

  // ---------------------------------------------------------------------------
  // Source code and sleep checks
  // ---------------------------------------------------------------------------
  chk_timeout_order: assert property (req[1] && !req[0] |=> interruptSourceReg[5:0] == CODE_RXTO)
    else $error("timeout not ahead of data");
  chk_tx_code: assert property (req[3] && req[2:0] == 3'h0 |=> interruptSourceReg[5:0] == CODE_TXRDY)
    else $error("transmit ready code wrong");
  chk_pin_code: assert property (req[5] && req[4:0] == 5'h00 |=> interruptSourceReg[5:0] == CODE_PIN)
    else $error("pin change code wrong");
  chk_swfc_code: assert property (req[6] && req[5:0] == 6'h00 |=> interruptSourceReg[5:0] == CODE_SWFC)
    else $error("flow control code wrong");
  chk_xoff_set: assert property (events.xoffSeen |=> xoffFlag)
    else $error("xoff cause not latched");
  chk_sleep_pending: assert property (st_reg.slp == SLP_AWAKE && anyReq |=> st_reg.slp == SLP_AWAKE)
    else $error("sleep entered with interrupt pending");
endmodule : uieid_core // uieid_core
`default_nettype wire

// *** logic/uieid_pkg.sv ***
`default_nettype none
package uieid_pkg;
  // ---------------------------------------------------------------------------
  // Register addresses and line-format selects
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFF_MASK     = 4'h1;
  localparam logic [3:0] OFF_SOURCE   = 4'h2;
  localparam logic [7:0] LFMT_EXT_KEY = 8'hbf;
  localparam int         LFMT_DLAB    = 7;
  localparam int         EXT_UNLOCK   = 4;

  // ---------------------------------------------------------------------------
  // Mask register bit positions
  // ---------------------------------------------------------------------------
  localparam int M_RXDATA = 0;
  localparam int M_TXRDY  = 1;
  localparam int M_LINE   = 2;
  localparam int M_MODEM  = 3;
  localparam int M_SLEEP  = 4;
  localparam int M_SWFC   = 5;
  localparam int M_RTSDTR = 6;
  localparam int M_CTSDSR = 7;

  // ---------------------------------------------------------------------------
  // Reset values and source codes (bits 5..0)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] DIVHI_RESET  = 8'h00;
  localparam logic [7:0] SOURCE_IDLE  = 8'h01;
  localparam logic [5:0] CODE_LINE    = 6'h06;
  localparam logic [5:0] CODE_RXTO    = 6'h0c;
  localparam logic [5:0] CODE_RXDATA  = 6'h04;
  localparam logic [5:0] CODE_TXRDY   = 6'h02;
  localparam logic [5:0] CODE_MODEM   = 6'h00;
  localparam logic [5:0] CODE_PIN     = 6'h30;
  localparam logic [5:0] CODE_SWFC    = 6'h10;
  localparam logic [5:0] CODE_CTSRTS  = 6'h20;
  localparam logic [5:0] CODE_NONE    = 6'h01;
  localparam int         FIFO_DEPTH   = 64;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       lineErr;
    logic       rxTimeout;
    logic       rxData;
    logic       pinChange;
    logic       ctsRtsOff;
    logic       modemChange;
    logic       xoffSeen;
    logic       xonSeen;
    logic       specialSeen;
  } uieid_events_t;

  typedef struct packed {
    logic       fifoEnable;
    logic [6:0] txFree;
    logic [6:0] txTrigger;
    logic       txHoldEmpty;
    logic       txEmpty;
    logic       rxEmpty;
  } uieid_queue_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } uieid_hostreq_t;

  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b01,
    SLP_ASLEEP = 2'b10
  } uieid_sleep_t;
endpackage : uieid_pkg
`default_nettype wire

// *** logic/uieid_prio_pick.sv ***
`default_nettype none
// -----------------------------------------------------------------------------
// Fixed-priority encoder: lowest index wins
// -----------------------------------------------------------------------------
module uieid_prio_pick #(
  parameter int N = 8
) (
  // Request vector and winner
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] grant,
  output logic              any
);
  import uieid_pkg::*;

  // Elaboration guard: an empty request vector has no lowest bit
  if (N < 1) begin : g_badWidth
    $error("uieid_prio_pick: N must be at least 1");
  end

  // Isolate lowest set bit
  always_comb begin
    grant = req & (~req + N'(1));
    any   = |req;
  end
endmodule : uieid_prio_pick // uieid_prio_pick
`default_nettype wire

// *** logic/uieid_sticky.sv ***
`default_nettype none
// -----------------------------------------------------------------------------
// Sticky flag: set wins over clear
// -----------------------------------------------------------------------------
module uieid_sticky (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Control
  input  wire logic setEn,
  input  wire logic clrEn,
  output logic      flag
);
  import uieid_pkg::*;

  logic flag_reg;
  logic flag_next;

  // Set beats clear so a same-cycle event is not lost
  always_comb begin
    flag_next = flag_reg;
    if (clrEn) flag_next = 1'b0;
    if (setEn) flag_next = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) flag_reg <= 1'b0;
    else flag_reg <= flag_next;
  end

  assign flag = flag_reg;
endmodule : uieid_sticky // uieid_sticky
`default_nettype wire

// *** test/uieid_bench.sv ***
`default_nettype none
module uieid_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import uieid_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic           mclk, rstn, porRstn, modemToggle, rxPin, txWrite;
  logic           irqPending, sleepStopOsc, wakeRequest;
  uieid_hostreq_t hostReq;
  uieid_events_t  events;
  uieid_queue_t   queue;
  logic     [7:0] lineFormat, extFeature, hostRdata, interruptMaskReg, baudDivisorHigh, interruptSourceReg;
  logic     [7:0] rdv, m, e;
  logic    [31:0] rnd;
  int             err_count, n_tests;

  uieid_core dut (.mclk(mclk), .rstn(rstn), .porRstn(porRstn), .hostReq(hostReq), .hostRdata(hostRdata),
    .lineFormat(lineFormat), .extFeature(extFeature), .events(events), .queue(queue),
    .modemToggle(modemToggle), .rxPin(rxPin), .txWrite(txWrite), .interruptMaskReg(interruptMaskReg),
    .baudDivisorHigh(baudDivisorHigh), .interruptSourceReg(interruptSourceReg), .irqPending(irqPending),
    .sleepStopOsc(sleepStopOsc), .wakeRequest(wakeRequest));
  uieid_host_model host (.mclk(mclk), .hostRdata(hostRdata), .hostReq(hostReq),
    .lineFormat(lineFormat), .extFeature(extFeature));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected source byte: first enabled cause in priority order, the flow-control cause left out
  function automatic logic [7:0] exp_src(input logic [7:0] k, input uieid_events_t v, input uieid_queue_t q);
    logic [5:0] c;
    logic       tx;
    tx = q.fifoEnable ? (q.txFree > q.txTrigger) : q.txHoldEmpty;
    if (k[2] && v.lineErr) c = CODE_LINE;
    else if (k[0] && v.rxTimeout) c = CODE_RXTO;
    else if (k[0] && v.rxData) c = CODE_RXDATA;
    else if (k[1] && tx) c = CODE_TXRDY;
    else if (k[3] && v.modemChange) c = CODE_MODEM;
    else if (k[6] && v.pinChange) c = CODE_PIN;
    else if (k[7] && v.ctsRtsOff) c = CODE_CTSRTS;
    else c = CODE_NONE;
    return {q.fifoEnable, q.fifoEnable, c};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Let n edges pass, then look at settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Hang guard: far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    err_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    close_out();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rstn, porRstn, modemToggle, txWrite} = 4'h0;
    rxPin = 1'b1;
    events = '0;
    queue = '0;
    rnd = 32'hb8c4;
    m = 8'h00;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    cyc(0);
    chk(interruptMaskReg, MASK_RESET, "mask reset");
    chk(interruptSourceReg, SOURCE_IDLE, "source reset");
    chk(baudDivisorHigh, DIVHI_RESET, "divisor reset");
    // Divisor byte: selected by bit 7, refused under the extended key
    host.set_cfg(8'h80, 8'h00);
    host.access(1'b1, OFF_MASK, 8'h5a, rdv);
    cyc(0);
    chk(baudDivisorHigh, 8'h5a, "divisor write");
    chk(interruptMaskReg, 8'h00, "mask untouched by divisor write");
    host.access(1'b0, OFF_MASK, 8'h00, rdv);
    chk(rdv, 8'h5a, "divisor read");
    host.set_cfg(8'hbf, 8'h00);
    host.access(1'b1, OFF_MASK, 8'h33, rdv);
    cyc(0);
    chk(baudDivisorHigh, 8'h5a, "divisor under key");
    host.access(1'b0, OFF_MASK, 8'h00, rdv);
    chk(rdv, 8'h00, "offset 1 under key");
    @(posedge mclk) rstn <= 1'b0;
    @(posedge mclk) rstn <= 1'b1;
    cyc(0);
    chk(baudDivisorHigh, 8'h5a, "divisor kept over reset");
    @(posedge mclk) porRstn <= 1'b0;
    @(posedge mclk) porRstn <= 1'b1;
    cyc(0);
    chk(baudDivisorHigh, 8'h00, "divisor power-on clear");
    // Upper mask bits locked unless unlocked; queues not empty, so no sleep
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      host.set_cfg(8'h00, {3'h0, i[0], 4'h0});
      host.access(1'b1, OFF_MASK, rnd[7:0], rdv);
      if (i[0]) m = rnd[7:0];
      else m[3:0] = rnd[3:0];
      cyc(0);
      chk(interruptMaskReg, m, "mask write");
      host.access(1'b0, OFF_MASK, 8'h00, rdv);
      chk(rdv, m, "mask read");
    end
    // Random sources, masks and queue states; first pass has every source on except the flow-control causes
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      m = rnd[7:0] & 8'hef;
      host.access(1'b1, OFF_MASK, m, rdv);
      rnd = lfsr(rnd);
      e[5:0] = (i == 0) ? 6'h3f : rnd[5:0] & rnd[27:22];
      events <= '{lineErr: e[0], rxTimeout: e[1], rxData: e[2], pinChange: e[3], ctsRtsOff: e[4],
                  modemChange: e[5], default: 1'b0};
      queue <= '{fifoEnable: rnd[6], txFree: rnd[13:7], txTrigger: rnd[20:14], txHoldEmpty: rnd[21],
                 default: 1'b0};
      cyc(1);
      e = exp_src(m, events, queue);
      chk(interruptSourceReg, e, "source code");
      chk({7'h0, irqPending}, {7'h0, !e[0]}, "pending flag");
      host.access(1'b0, OFF_SOURCE, 8'h00, rdv);
      chk(rdv, e, "source read");
    end
    events <= '0;
    queue <= '0;
    // Flow-control cause: Xoff held until Xon, special until a source read
    host.set_cfg(8'h00, 8'h10);
    host.access(1'b1, OFF_MASK, 8'h20, rdv);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) events <= k ? uieid_events_t'{specialSeen: 1'b1, default: 1'b0}
                                  : uieid_events_t'{xoffSeen: 1'b1, default: 1'b0};
      @(posedge mclk) events <= '0;
      cyc(1);
      chk(interruptSourceReg, {2'b00, CODE_SWFC}, "flow control cause");
      cyc(3);
      chk(interruptSourceReg, {2'b00, CODE_SWFC}, "flow control held");
      if (k == 0) begin
        @(posedge mclk) events <= '{xonSeen: 1'b1, default: 1'b0};
        @(posedge mclk) events <= '0;
      end else begin
        host.access(1'b0, OFF_SOURCE, 8'h00, rdv);
        chk(rdv, {2'b00, CODE_SWFC}, "special cause read");
      end
      cyc(2);
      chk(interruptSourceReg, SOURCE_IDLE, "flow control cleared");
    end
    // Sleep held off by a pending cause, then entry with idle queues, then each wake cause
    @(posedge mclk);
    queue <= '{txEmpty: 1'b1, rxEmpty: 1'b1, default: 1'b0};
    events <= '{rxData: 1'b1, default: 1'b0};
    host.access(1'b1, OFF_MASK, 8'h11, rdv);
    cyc(3);
    chk({7'h0, sleepStopOsc}, 8'h00, "no sleep while pending");
    host.access(1'b1, OFF_MASK, 8'h10, rdv);
    cyc(3);
    chk({7'h0, sleepStopOsc}, 8'h01, "sleep entered");
    for (int w = 0; w < 5; w++) begin
      @(posedge mclk);
      modemToggle <= (w == 0);
      rxPin <= (w != 1);
      txWrite <= (w >= 2);
      if (w >= 3) queue <= w[0] ? uieid_queue_t'{rxEmpty: 1'b1, default: 1'b0}
                                : uieid_queue_t'{txEmpty: 1'b1, default: 1'b0};
      @(negedge mclk);
      chk({7'h0, wakeRequest}, 8'h01, "wake request");
      chk({7'h0, sleepStopOsc}, 8'h00, "oscillator restarted");
      @(posedge mclk);
      {modemToggle, txWrite} <= 2'b00;
      rxPin <= 1'b1;
      cyc(3);
      chk({7'h0, sleepStopOsc}, {7'h0, w < 3}, "sleep re-entry");
      @(posedge mclk) queue <= '{txEmpty: 1'b1, rxEmpty: 1'b1, default: 1'b0};
      cyc(3);
    end
    host.set_cfg(8'h00, 8'h00);
    cyc(3);
    chk({7'h0, sleepStopOsc}, 8'h00, "no sleep when locked");
    close_out();
  end
endmodule // uieid_bench
`default_nettype wire

// *** test/uieid_host_model.sv ***
`default_nettype none
module uieid_host_model
  import uieid_pkg::*;
(
  // Clock and read data back from the channel
  input  wire logic                     mclk,
  input  wire logic               [7:0] hostRdata,
  // Register port and neighbouring configuration
  output var  uieid_pkg::uieid_hostreq_t hostReq,
  output var  logic               [7:0] lineFormat,
  output var  logic               [7:0] extFeature
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------------------
  // Idle state at time zero
  // ---------------------------------------------------------------------------
  initial begin
    hostReq    = '0;
    lineFormat = 8'h00;
    extFeature = 8'h00;
  end

  // Neighbouring registers the host owns; changed just after an edge
  task automatic set_cfg(input logic [7:0] fmt, input logic [7:0] ext);
    @(posedge mclk);
    lineFormat <= fmt;
    extFeature <= ext;
  endtask

  // One access, held through its sampling edge, then released
  task automatic access(input logic wr, input logic [3:0] addr, input logic [7:0] data,
                        output logic [7:0] rdOut);
    @(posedge mclk);
    hostReq <= '{sel: 1'b1, wr: wr, rd: !wr, addr: addr, wdata: data};
    // Read data taken at the sampling edge, before anything is released
    @(posedge mclk);
    rdOut = hostRdata;
    // Released address and data lines show the inverse, so a stale value never looks valid
    hostReq <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask
endmodule // uieid_host_model
`default_nettype wire
